// *** sim/ras_core_model.sv ***
/* core side partner: drives pushes and pops, records the answers.
 assumes the stack answers a pop one cycle after taking it. */
`timescale 1ns/100ps
module ras_core_model
   import ras_pkg::*;
(
   input wire logic clk,
   input wire ras_pop_rsp_t pop_rsp,
   input wire logic fault_reset,
   output ras_core_req_t core_req
);
   ras_pop_rsp_t last_rsp;
   int faults = 0;
   initial core_req = '0;
   always @(posedge clk) begin
      if (pop_rsp.valid)
         last_rsp <= pop_rsp;
      if (fault_reset)
         faults <= faults + 1;
   end
   task automatic op(input logic p, input logic q, input logic [RAS_PC_W-1:0] pc);
      @(posedge clk);
      core_req <= '{p, q, pc};
   endtask
endmodule

// *** sim/ras_stack_properties.sv ***
/* checker of port relations of the stack block.
 assumes it is bound to the stack top module. */
`timescale 1ns/100ps
module ras_stack_props
   import ras_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire ras_core_req_t core_req,
   input wire ras_pop_rsp_t pop_rsp,
   input wire logic fault_reset,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   property p_wait_ans; (avs_read || avs_write) |-> ##[0:2] !avs_waitrequest; endproperty
   a_wait_ans: assert property (p_wait_ans) else $error("bus not answered");
   property p_pop; core_req.pop && !core_req.push |=> pop_rsp.valid; endproperty
   a_pop: assert property (p_pop) else $error("pop not answered");
   property p_push; core_req.push |=> !pop_rsp.valid; endproperty
   a_push: assert property (p_push) else $error("push answered as pop");
   property p_unf; pop_rsp.underflow |-> pop_rsp.valid && pop_rsp.pc == '0; endproperty
   a_unf: assert property (p_unf) else $error("underflow pc not zero");
   property p_fault; fault_reset |-> $past(core_req.push || core_req.pop); endproperty
   a_fault: assert property (p_fault) else $error("fault without cause");
   property p_fault_unf; fault_reset && !$past(core_req.push) |-> pop_rsp.underflow; endproperty
   a_fault_unf: assert property (p_fault_unf) else $error("pop fault no underflow");
   property p_rst; $fell(reset) |-> avs_waitrequest && !irq && !fault_reset; endproperty
   a_rst: assert property (p_rst) else $error("outputs not reset");
endmodule
bind ras_return_address_stack ras_stack_props chk_u(.clk(clk), .reset(reset),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .core_req(core_req), .pop_rsp(pop_rsp), .fault_reset(fault_reset), .irq(irq));

// *** sim/return_address_stack_test.sv ***
/* bench of the return address stack: bus tasks, core model, checks.
 assumes the bus answers within 50 cycles. */
`timescale 1ns/100ps
module return_address_stack_test;
   import ras_pkg::*;
   logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, irq, fault_reset, avs_waitrequest;
   logic [4:0] avs_address = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_writedata = '0, avs_readdata, q;
   ras_core_req_t core_req;
   ras_pop_rsp_t pop_rsp;
   int err_count = 0, n_checks = 0;
   always #2 clk = ~clk;
   ras_return_address_stack dut_u(.clk(clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .core_req(core_req), .pop_rsp(pop_rsp), .fault_reset(fault_reset), .irq(irq));
   ras_core_model core_u(.clk(clk), .pop_rsp(pop_rsp), .fault_reset(fault_reset),
      .core_req(core_req));
   task automatic results();
      $display("checks %0d wrong %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_read <= !w;
      avs_write <= w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
      if (n >= 50) begin
         err_count++;
         results();
      end
   endtask
   task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e);
      xfer(0, a, 0);
      chk(nm, q, e);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      reset <= 0;
      rc("ptr", RAS_OFS_PTR, 0);
      rc("cfg", RAS_OFS_CONFIG, 1);
      xfer(1, RAS_OFS_PTR, 32'h3f);
      rc("ptr", RAS_OFS_PTR, 32'h1f);
      avs_byteenable <= 4'h0;
      xfer(1, RAS_OFS_PTR, 32'h5);
      avs_byteenable <= 4'hf;
      rc("ptr", RAS_OFS_PTR, 32'h1f);
      xfer(1, RAS_OFS_PTR, 0);
      xfer(1, RAS_OFS_INT_MASK, 32'h3);
      $display("test registers done");
      core_u.op(1, 0, 21'h1a0001);
      core_u.op(1, 0, 21'h000123);
      core_u.op(0, 0, 0);
      rc("ptr", RAS_OFS_PTR, 2);
      rc("high", RAS_OFS_TOS_HIGH, 32'h01);
      core_u.op(0, 1, 0);
      core_u.op(0, 0, 0);
      rc("up", RAS_OFS_TOS_UPPER, 32'h1a);
      chk("pc", core_u.last_rsp.pc, 21'h000123);
      xfer(1, RAS_OFS_TOS_LOW, 32'h55);
      rc("low", RAS_OFS_TOS_LOW, 32'h55);
      xfer(1, RAS_OFS_TOS_HIGH, 32'h66);
      rc("high", RAS_OFS_TOS_HIGH, 32'h66);
      xfer(1, RAS_OFS_TOS_UPPER, 32'h15);
      rc("up", RAS_OFS_TOS_UPPER, 32'h15);
      core_u.op(0, 1, 0);
      core_u.op(0, 1, 0);
      core_u.op(0, 0, 0);
      rc("unf", RAS_OFS_PWR_STATUS, 32'h2);
      chk("pc", core_u.last_rsp.pc, 0);
      chk("flt", core_u.faults, 1);
      chk("irq", irq, 1);
      rc("ists", RAS_OFS_INT_STATUS, 32'h2);
      rc("mask", RAS_OFS_INT_MASK, 32'h3);
      xfer(1, RAS_OFS_INT_STATUS, 32'h3);
      xfer(1, RAS_OFS_PWR_STATUS, 0);
      rc("unf", RAS_OFS_PWR_STATUS, 0);
      chk("irq", irq, 0);
      $display("test push pop done");
      xfer(1, RAS_OFS_CONFIG, 0);
      for (int i = 1; i <= 31; i++)
         core_u.op(1, 0, 21'(i));
      core_u.op(0, 0, 0);
      rc("ovf", RAS_OFS_PWR_STATUS, 0);
      core_u.op(1, 0, 21'h20);
      core_u.op(0, 0, 0);
      rc("ptr", RAS_OFS_PTR, 32'h1f);
      rc("ovf", RAS_OFS_PWR_STATUS, 1);
      rc("low", RAS_OFS_TOS_LOW, 32'h20);
      xfer(1, RAS_OFS_PTR, 0);
      core_u.op(0, 1, 0);
      core_u.op(0, 0, 0);
      rc("flags", RAS_OFS_PWR_STATUS, 32'h3);
      chk("flt", core_u.faults, 1);
      chk("pc", core_u.last_rsp.pc, 0);
      chk("unf", core_u.last_rsp.underflow, 1);
      $display("test fault disabled done");
      xfer(1, RAS_OFS_CONFIG, 1);
      xfer(1, RAS_OFS_PWR_STATUS, 0);
      xfer(1, RAS_OFS_PTR, 32'h1f);
      core_u.op(1, 0, 21'h7);
      core_u.op(0, 0, 0);
      rc("ptr", RAS_OFS_PTR, 0);
      rc("ovf", RAS_OFS_PWR_STATUS, 1);
      chk("flt", core_u.faults, 2);
      xfer(1, RAS_OFS_PWR_STATUS, 0);
      rc("ovf", RAS_OFS_PWR_STATUS, 0);
      xfer(1, RAS_OFS_PWR_STATUS, 1);
      rc("ovf", RAS_OFS_PWR_STATUS, 1);
      chk("flt", core_u.faults, 2);
      $display("test fault enabled done");
      xfer(1, RAS_OFS_PTR, 32'h5);
      reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      rc("ptr", RAS_OFS_PTR, 0);
      rc("flags", RAS_OFS_PWR_STATUS, 0);
      rc("cfg", RAS_OFS_CONFIG, 1);
      chk("irq", irq, 0);
      $display("test reset done");
      results();
   end
endmodule

// *** src/ras_pkg.sv ***
/*
 return address stack package: register map, field positions,
 reset values and the core-side request and answer structs.
 assumes a 32-bit avalon-mm slave port with byte addresses.
*/
package ras_pkg;
   localparam int RAS_PC_W = 21;
   localparam int RAS_ADDR_W = 5;
   localparam int RAS_PTR_W = 5;
   localparam logic [4:0] RAS_PTR_MAX = 5'h1f;
   localparam logic [4:0] RAS_PTR_RST = 5'h00;
   localparam logic [4:0] RAS_OFS_PTR = 5'h00;
   localparam logic [4:0] RAS_OFS_TOS_LOW = 5'h04;
   localparam logic [4:0] RAS_OFS_TOS_HIGH = 5'h08;
   localparam logic [4:0] RAS_OFS_TOS_UPPER = 5'h0c;
   localparam logic [4:0] RAS_OFS_PWR_STATUS = 5'h10;
   localparam logic [4:0] RAS_OFS_CONFIG = 5'h14;
   localparam logic [4:0] RAS_OFS_INT_STATUS = 5'h18;
   localparam logic [4:0] RAS_OFS_INT_MASK = 5'h1c;
   localparam int RAS_BIT_OVF = 0;
   localparam int RAS_BIT_UNF = 1;
   localparam int RAS_BIT_FAULT_EN = 0;
   localparam logic RAS_FAULT_EN_RST = 1'b1;
   localparam logic [1:0] RAS_FLAGS_RST = 2'h0;
   localparam logic [1:0] RAS_MASK_RST = 2'h0;

   typedef struct packed {
      logic push;
      logic pop;
      logic [RAS_PC_W-1:0] pc;
   } ras_core_req_t;

   typedef struct packed {
      logic valid;
      logic underflow;
      logic [RAS_PC_W-1:0] pc;
   } ras_pop_rsp_t;

   typedef enum logic [1:0] {
      RAS_BUS_IDLE = 2'b00,
      RAS_BUS_ACK = 2'b01
   } ras_bus_state_t;
endpackage

// *** src/ras_return_address_stack.sv ***
/*
 return address stack with avalon-mm register access, sticky
 overflow and underflow flags, optional stack fault reset request
 and a masked level interrupt.
 assumes the core drives at most one push or pop per cycle and
 turns fault_reset into a device reset; reset here is power-on.
*/
`timescale 1ns/100ps
module ras_return_address_stack
   import ras_pkg::*;
#(
   parameter int PC_W = RAS_PC_W
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [RAS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire ras_core_req_t core_req,
   output ras_pop_rsp_t pop_rsp,
   output logic fault_reset,
   output logic irq
);
   localparam int DEPTH = 32;

   logic [PC_W-1:0] stack_reg [DEPTH];
   logic [PC_W-1:0] stack_next [DEPTH];
   logic [RAS_PTR_W-1:0] ptr_reg;
   logic [RAS_PTR_W-1:0] ptr_next;
   logic [1:0] flags_reg;
   logic [1:0] flags_next;
   logic fault_en_reg;
   logic fault_en_next;
   logic [1:0] int_status_reg;
   logic [1:0] int_status_next;
   logic [1:0] int_mask_reg;
   logic [1:0] int_mask_next;
   ras_bus_state_t bus_reg;
   ras_bus_state_t bus_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic wait_reg;
   logic wait_next;
   ras_pop_rsp_t rsp_reg;
   ras_pop_rsp_t rsp_next;
   logic fault_reg;
   logic fault_next;
   logic irq_reg;
   logic irq_next;

   logic bus_wr;
   logic [1:0] ev;
   logic [PC_W-1:0] top_of_stack;
   logic [31:0] tos_word;

   assign top_of_stack = stack_reg[ptr_reg];
   assign tos_word = 32'(top_of_stack);
   // a write is taken at the edge where waitrequest is seen low
   assign bus_wr = avs_write && (bus_reg == RAS_BUS_ACK);

   // bus slave: one wait cycle, then the answer
   always_comb begin
      bus_next = bus_reg;
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      case (bus_reg)
         RAS_BUS_IDLE: begin
            if (avs_read || avs_write) begin
               bus_next = RAS_BUS_ACK;
               wait_next = 1'b0;
               rdata_next = 32'h0000_0000;
               case (avs_address)
                  RAS_OFS_PTR: rdata_next = 32'(ptr_reg);
                  RAS_OFS_TOS_LOW: rdata_next = 32'(tos_word[7:0]);
                  RAS_OFS_TOS_HIGH: rdata_next = 32'(tos_word[15:8]);
                  RAS_OFS_TOS_UPPER: rdata_next = 32'(tos_word[23:16]);
                  RAS_OFS_PWR_STATUS: rdata_next = 32'(flags_reg);
                  RAS_OFS_CONFIG: rdata_next = 32'(fault_en_reg);
                  RAS_OFS_INT_STATUS: rdata_next = 32'(int_status_reg);
                  RAS_OFS_INT_MASK: rdata_next = 32'(int_mask_reg);
                  default: rdata_next = 32'h0000_0000;
               endcase
            end
         end
         RAS_BUS_ACK: begin
            bus_next = RAS_BUS_IDLE;
         end
         default: begin
            bus_next = RAS_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         bus_reg <= RAS_BUS_IDLE;
         wait_reg <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end else begin
         bus_reg <= bus_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
      end
   end

   // stack, pointer and flags
   always_comb begin
      logic [RAS_PTR_W-1:0] up;
      up = ptr_reg + 5'h01;
      stack_next = stack_reg;
      ptr_next = ptr_reg;
      flags_next = flags_reg;
      fault_en_next = fault_en_reg;
      ev = 2'h0;
      fault_next = 1'b0;
      rsp_next = '0;
      if (bus_wr && avs_byteenable[0]) begin
         case (avs_address)
            RAS_OFS_PTR: ptr_next = avs_writedata[RAS_PTR_W-1:0];
            RAS_OFS_TOS_LOW: stack_next[ptr_reg][7:0] = avs_writedata[7:0];
            RAS_OFS_TOS_HIGH: stack_next[ptr_reg][15:8] = avs_writedata[7:0];
            RAS_OFS_TOS_UPPER:
               stack_next[ptr_reg][PC_W-1:16] = avs_writedata[PC_W-17:0];
            RAS_OFS_PWR_STATUS: flags_next = avs_writedata[1:0];
            RAS_OFS_CONFIG: fault_en_next = avs_writedata[RAS_BIT_FAULT_EN];
            default: begin
            end
         endcase
      end
      // the core wins over a software write in the same cycle
      if (core_req.push) begin
         if (ptr_reg == RAS_PTR_MAX) begin
            ev[RAS_BIT_OVF] = 1'b1;
            flags_next[RAS_BIT_OVF] = 1'b1;
            if (fault_en_reg) begin
               ptr_next = RAS_PTR_RST;
               fault_next = 1'b1;
            end else begin
               ptr_next = RAS_PTR_MAX;
               stack_next[RAS_PTR_MAX] = core_req.pc;
            end
         end else begin
            ptr_next = up;
            stack_next[up] = core_req.pc;
         end
      end else if (core_req.pop) begin
         rsp_next.valid = 1'b1;
         if (ptr_reg == RAS_PTR_RST) begin
            // zero vectors to the reset address, pointer and entries untouched, underflow flag set
            rsp_next.pc = '0;
            rsp_next.underflow = 1'b1;
            ev[RAS_BIT_UNF] = 1'b1;
            flags_next[RAS_BIT_UNF] = 1'b1;
            fault_next = fault_en_reg;
         end else begin
            rsp_next.pc = top_of_stack;
            ptr_next = ptr_reg - 5'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ptr_reg <= RAS_PTR_RST;
         flags_reg <= RAS_FLAGS_RST;
         fault_en_reg <= RAS_FAULT_EN_RST;
         fault_reg <= 1'b0;
         rsp_reg <= '0;
      end else begin
         ptr_reg <= ptr_next;
         flags_reg <= flags_next;
         fault_en_reg <= fault_en_next;
         fault_reg <= fault_next;
         rsp_reg <= rsp_next;
      end
   end

   // entry storage needs no reset; one register per entry
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_entry
         always_ff @(posedge clk) begin
            stack_reg[gi] <= stack_next[gi];
         end
      end
   endgenerate

   // interrupt: sticky events, set beats a same-cycle clear
   always_comb begin
      int_status_next = int_status_reg;
      int_mask_next = int_mask_reg;
      if (bus_wr && avs_byteenable[0]) begin
         if (avs_address == RAS_OFS_INT_STATUS) begin
            int_status_next = int_status_reg & ~avs_writedata[1:0];
         end
         if (avs_address == RAS_OFS_INT_MASK) begin
            int_mask_next = avs_writedata[1:0];
         end
      end
      int_status_next = int_status_next | ev;
      irq_next = |(int_status_next & int_mask_next);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         int_status_reg <= RAS_FLAGS_RST;
         int_mask_reg <= RAS_MASK_RST;
         irq_reg <= 1'b0;
      end else begin
         int_status_reg <= int_status_next;
         int_mask_reg <= int_mask_next;
         irq_reg <= irq_next;
      end
   end

   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign pop_rsp = rsp_reg;
   assign fault_reset = fault_reg;
   assign irq = irq_reg;
endmodule
